// ===== design/sadc_params.svh
// Offsets, field positions and timing counts of the converter sequencer.
// Assumes inclusion by its bare name from the design module, the checker and the bench.
`ifndef SADC_PARAMS_SVH
`define SADC_PARAMS_SVH
// ==========================================================================
// Register offsets (byte addresses on the plain register port).
`define SADC_OFF_STS 8'h00
`define SADC_OFF_IEN 8'h04
`define SADC_OFF_CTRL 8'h08
`define SADC_OFF_CFG1 8'h0C
`define SADC_OFF_CHSEL 8'h28
`define SADC_OFF_DATA 8'h40
`define SADC_OFF_CCFG 8'hC8
// ==========================================================================
// Status and enable bit positions.
`define SADC_B_RDY 0
`define SADC_B_EOSMP 1
`define SADC_B_EOC 2
`define SADC_B_EOSEQ 3
`define SADC_B_OVR 4
`define SADC_B_AWD 7
`define SADC_FLAG_MASK 8'h9F
// ==========================================================================
// Control bit positions.
`define SADC_C_EN 0
`define SADC_C_START 2
`define SADC_C_CAL 31
// ==========================================================================
// Configuration 1 field positions, and the sensor enable bit of the CCFG register.
`define SADC_F_RES_LO 3
`define SADC_F_ALIGN 5
`define SADC_F_TSEL_LO 6
`define SADC_F_EDGE_LO 10
`define SADC_F_CONT 13
`define SADC_F_DISC 16
`define SADC_CCFG_TEMP_SENSOR_ENABLE 23
// ==========================================================================
// Conversion timing in converter clocks: sample plus approximation, per resolution.
`define SADC_T_RES12 5'd14
`define SADC_T_RES10 5'd13
`define SADC_T_RES8 5'd11
`define SADC_T_RES6 5'd9
`define SADC_T_SAMPLE 5'd2
`define SADC_T_CAL 5'd16
`define SADC_T_READY 5'd2
`endif

// ===== design/sadc_pkg.sv
// Types shared by the converter sequencer.
// Assumes compilation before sadc_top, which uses its types; it needs no constants header.
package sadc_pkg;
  typedef enum logic [2:0] {
    SADC_OFF,
    SADC_IDLE,
    SADC_CAL,
    SADC_SAMPLE,
    SADC_CONVERT
  } sadc_state_t;
  typedef enum logic [1:0] {
    SADC_EDGE_NONE,
    SADC_EDGE_RISE,
    SADC_EDGE_FALL,
    SADC_EDGE_BOTH
  } sadc_edge_t;
endpackage : sadc_pkg

// ===== design/sadc_top.sv
// Sequencer and register file for a 12-bit successive-approximation converter.
// Assumes a synchronous register port, triggers synchronous to clk, and a core
// that holds a result word and a calibration factor valid when the sequencer's cycle count ends.
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`include "sadc_params.svh"

// Summary of operation
// - Calibration bit clears itself when calibration finishes.
// - Calibration factor reads back in data register bits 6 to 0.
// - No conversion starts while calibration is running.
// - Single mode converts the channel or group once, then stops.
// - Conversion starts by software start bit or selected hardware trigger edge.
// - Continuous mode repeats the channel or group without new starts.
// - Each result goes to the data register and sets end-of-conversion flag.
// - Last channel of the sequence sets the end-of-sequence flag.
// - Discontinuous mode converts one next channel per start.
// - Without discontinuous mode one start converts the whole sequence.
// - Channels 0-15 external, 16 temperature, 17 reference, 18 battery.
// - Temperature sensor powered only while its enable bit is set.
// - Three-bit field picks the trigger source; 111 is the external pin.
// - Two-bit field picks none, rising, falling or both trigger edges.
// - Hardware triggers count only with a nonzero edge field.
// - Alignment bit chooses left or right justified results.
// - Two-bit field picks 12, 10, 8 or 6 bit resolution.
// - Conversions take 14, 13, 11 or 9 converter clocks.
// - Six event flags each with its own enable bit.
// - Flags are set by hardware and cleared by writing one.
module sadc_top #(
  parameter int NUM_CH = 19
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [4:0] timer_trigger_input,
  input wire logic ext_trigger_pin,
  input wire logic [11:0] core_result,
  input wire logic [6:0] core_cal_factor,
  input wire logic window_event,
  output logic [4:0] channel_select,
  output logic core_sample,
  output logic core_power,
  output logic temp_sensor_enable,
  output logic irq
);

  // The channel mask, the scan and the select width are sized for nineteen inputs only.
  if (NUM_CH != 19) begin : g_num_ch_check
    $error("sadc_top serves exactly 19 channels");
  end

  // ==========================================================================
  // Register state.
  logic converter_enable;
  logic calibrate;
  logic conversion_start;
  logic [1:0] resolution_select;
  logic result_alignment;
  logic [2:0] trigger_source_select;
  logic [1:0] trigger_edge_select;
  logic continuous_mode_select;
  logic discontinuous_enable;
  logic [7:0] flags;
  logic [7:0] irq_en;
  logic [18:0] chan_mask;
  logic [15:0] data_word;
  sadc_pkg::sadc_state_t state;
  logic [4:0] cycle_cnt;
  logic [4:0] cur_ch;
  logic trig_q;
  logic trig_prev;
  logic wr_sts;
  logic wr_ctrl;
  logic [7:0] set_flags;
  logic seq_done;
  logic conv_done;
  logic cal_done;
  logic hw_edge;
  logic go;
  logic [4:0] conv_len;
  logic [4:0] next_ch;
  logic next_has;
  logic [4:0] first_ch;
  logic [15:0] aligned;
  logic temp_sensor_enable_bit;

  assign wr_sts = reg_wr && (reg_addr == `SADC_OFF_STS);
  assign wr_ctrl = reg_wr && (reg_addr == `SADC_OFF_CTRL);

  // ==========================================================================
  // Trigger source and edge detection.
  always_comb begin
    trig_q = (trigger_source_select == 3'h7) ? ext_trigger_pin :
      (trigger_source_select <= 3'h4) ? timer_trigger_input[trigger_source_select] : 1'b0;
  end

  // The previous level follows the selected source at all times, so a change of edge field never
  // fakes an edge, but a change of source can, when the old and new sources differ in level.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_q;
    end
  end

  always_comb begin
    case (sadc_pkg::sadc_edge_t'(trigger_edge_select))
      sadc_pkg::SADC_EDGE_RISE: hw_edge = trig_q && !trig_prev;
      sadc_pkg::SADC_EDGE_FALL: hw_edge = !trig_q && trig_prev;
      sadc_pkg::SADC_EDGE_BOTH: hw_edge = trig_q != trig_prev;
      default: hw_edge = 1'b0;
    endcase
  end

  // A start is honoured only from idle; calibration holds the machine elsewhere.
  assign go = (state == sadc_pkg::SADC_IDLE) && (conversion_start || hw_edge);

  // ==========================================================================
  // Channel scanning: next selected channel above the current one.
  // The loop runs downwards, so the last hit is the lowest channel that qualifies.
  always_comb begin
    next_has = 1'b0;
    next_ch = 5'h00;
    first_ch = 5'h00;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (chan_mask[i]) begin
        first_ch = 5'(i);
        if (5'(i) > cur_ch) begin
          next_has = 1'b1;
          next_ch = 5'(i);
        end
      end
    end
  end

  // Totals include the two-cycle sample phase; lower resolutions simply stop earlier.
  always_comb begin
    case (resolution_select)
      2'h0: conv_len = `SADC_T_RES12;
      2'h1: conv_len = `SADC_T_RES10;
      2'h2: conv_len = `SADC_T_RES8;
      default: conv_len = `SADC_T_RES6;
    endcase
  end

  // Lower resolutions leave the unused bits at zero: the low bits when left aligned, the high bits when right aligned.
  always_comb begin
    aligned = 16'h0000;
    case (resolution_select)
      2'h0: aligned = result_alignment ? {core_result, 4'h0} : {4'h0, core_result};
      2'h1: aligned = result_alignment ? {core_result[11:2], 6'h00} :
        {6'h00, core_result[11:2]};
      2'h2: aligned = result_alignment ? {core_result[11:4], 8'h00} :
        {8'h00, core_result[11:4]};
      default: aligned = result_alignment ? {core_result[11:6], 10'h000} :
        {10'h000, core_result[11:6]};
    endcase
  end

  assign conv_done = (state == sadc_pkg::SADC_CONVERT) && (cycle_cnt == conv_len - 5'd1);
  assign cal_done = (state == sadc_pkg::SADC_CAL) && (cycle_cnt == `SADC_T_CAL - 5'd1);
  assign seq_done = conv_done && !next_has;

  // ==========================================================================
  // Conversion sequencer.
  // Clearing the enable bit lets a running conversion count to its end and write the data register,
  // but core_power falls one cycle after the enable bit clears, so the core is unpowered for the rest of it.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= sadc_pkg::SADC_OFF;
      cycle_cnt <= 5'h00;
      cur_ch <= 5'h00;
    end else begin
      cycle_cnt <= cycle_cnt + 5'd1;
      case (state)
        sadc_pkg::SADC_OFF: begin
          cycle_cnt <= 5'h00;
          if (calibrate) begin
            state <= sadc_pkg::SADC_CAL;
          end else if (converter_enable && cycle_cnt == 5'h00) begin
            state <= sadc_pkg::SADC_IDLE;
          end
        end
        sadc_pkg::SADC_CAL: begin
          if (cal_done) begin
            state <= sadc_pkg::SADC_OFF;
          end
        end
        sadc_pkg::SADC_IDLE: begin
          cycle_cnt <= 5'h00;
          if (!converter_enable) begin
            state <= sadc_pkg::SADC_OFF;
          end else if (go && chan_mask != 19'h0) begin
            state <= sadc_pkg::SADC_SAMPLE;
            if (!discontinuous_enable || !next_has) begin
              cur_ch <= first_ch;
            end else begin
              cur_ch <= next_ch;
            end
          end
        end
        sadc_pkg::SADC_SAMPLE: begin
          if (cycle_cnt == `SADC_T_SAMPLE - 5'd1) begin
            state <= sadc_pkg::SADC_CONVERT;
          end
        end
        sadc_pkg::SADC_CONVERT: begin
          if (conv_done) begin
            cycle_cnt <= 5'h00;
            if (!converter_enable) begin
              state <= sadc_pkg::SADC_OFF;
            end else if (next_has && !discontinuous_enable) begin
              cur_ch <= next_ch;
              state <= sadc_pkg::SADC_SAMPLE;
            end else if (!next_has && continuous_mode_select) begin
              cur_ch <= first_ch;
              state <= sadc_pkg::SADC_SAMPLE;
            end else begin
              state <= sadc_pkg::SADC_IDLE;
            end
          end
        end
        default: state <= sadc_pkg::SADC_OFF;
      endcase
    end
  end

  // ==========================================================================
  // Core outputs.
  // The sensor draws power only while it is enabled and part of the sequence.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      channel_select <= 5'h00;
      core_sample <= 1'b0;
      core_power <= 1'b0;
      temp_sensor_enable <= 1'b0;
    end else begin
      channel_select <= cur_ch;
      core_sample <= state == sadc_pkg::SADC_SAMPLE;
      core_power <= converter_enable || calibrate;
      temp_sensor_enable <= chan_mask[16] ? temp_sensor_enable_bit : 1'b0;
    end
  end

  // ==========================================================================
  // Control and configuration registers.
  // A calibration request while enabled is ignored, as the core cannot calibrate mid-run.

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      converter_enable <= 1'b0;
      calibrate <= 1'b0;
      conversion_start <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        converter_enable <= reg_wdata[`SADC_C_EN];
      end
      if (cal_done) begin
        calibrate <= 1'b0;
      end else if (wr_ctrl && reg_wdata[`SADC_C_CAL] && !converter_enable) begin
        calibrate <= 1'b1;
      end
      if (go || !converter_enable) begin
        conversion_start <= 1'b0;
      end else if (wr_ctrl && reg_wdata[`SADC_C_START] && !calibrate) begin
        conversion_start <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resolution_select <= 2'h0;
      result_alignment <= 1'b0;
      trigger_source_select <= 3'h0;
      trigger_edge_select <= 2'h0;
      continuous_mode_select <= 1'b0;
      discontinuous_enable <= 1'b0;
      irq_en <= 8'h00;
      chan_mask <= 19'h0;
      temp_sensor_enable_bit <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `SADC_OFF_CFG1: begin
          resolution_select <= reg_wdata[`SADC_F_RES_LO +: 2];
          result_alignment <= reg_wdata[`SADC_F_ALIGN];
          trigger_source_select <= reg_wdata[`SADC_F_TSEL_LO +: 3];
          trigger_edge_select <= reg_wdata[`SADC_F_EDGE_LO +: 2];
          continuous_mode_select <= reg_wdata[`SADC_F_CONT];
          discontinuous_enable <= reg_wdata[`SADC_F_DISC];
        end
        `SADC_OFF_IEN: irq_en <= reg_wdata[7:0] & `SADC_FLAG_MASK;
        `SADC_OFF_CHSEL: chan_mask <= reg_wdata[18:0];
        `SADC_OFF_CCFG: temp_sensor_enable_bit <= reg_wdata[`SADC_CCFG_TEMP_SENSOR_ENABLE];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Event flags: a hardware set wins over a write-one clear in the same cycle.
  // Overrun is judged against the flag, as reads have no side effects here.
  always_comb begin
    set_flags = 8'h00;
    set_flags[`SADC_B_RDY] = (state == sadc_pkg::SADC_OFF) && converter_enable &&
      !calibrate;
    set_flags[`SADC_B_EOSMP] = (state == sadc_pkg::SADC_SAMPLE) &&
      (cycle_cnt == `SADC_T_SAMPLE - 5'd1);
    set_flags[`SADC_B_EOC] = conv_done;
    set_flags[`SADC_B_EOSEQ] = seq_done;
    set_flags[`SADC_B_OVR] = conv_done && flags[`SADC_B_EOC];
    set_flags[`SADC_B_AWD] = window_event;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags <= 8'h00;
    end else begin
      flags <= ((wr_sts ? flags & ~reg_wdata[7:0] : flags) | set_flags) & `SADC_FLAG_MASK;
    end
  end

  // Calibration and conversion never end in one cycle, so the priority order is moot.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_word <= 16'h0000;
    end else if (cal_done) begin
      data_word <= {9'h000, core_cal_factor};
    end else if (conv_done) begin
      data_word <= aligned;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & irq_en);
    end
  end

  // ==========================================================================
  // Read port: data one cycle after the strobe, zero elsewhere.
  // Polling the status register is harmless, as no read clears a flag.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SADC_OFF_STS: reg_rdata <= {24'h000000, flags};
        `SADC_OFF_IEN: reg_rdata <= {24'h000000, irq_en};
        `SADC_OFF_CTRL: reg_rdata <= {calibrate, 28'h0, conversion_start, 1'b0,
          converter_enable};
        `SADC_OFF_CFG1: reg_rdata <= {15'h0, discontinuous_enable, 2'h0,
          continuous_mode_select, 1'b0, trigger_edge_select, 1'b0,
          trigger_source_select, result_alignment, resolution_select, 3'h0};
        `SADC_OFF_CHSEL: reg_rdata <= {13'h0, chan_mask};
        `SADC_OFF_DATA: reg_rdata <= {16'h0000, data_word};
        `SADC_OFF_CCFG: reg_rdata <= {8'h00, temp_sensor_enable_bit, 23'h0};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule : sadc_top

// ===== testbench/sadc_core_model.sv
// Behavioural model of the analog multiplexer and converter core.
// Assumes the sequencer takes the result while powered and the factor at calibration end.
`timescale 1ns/100ps
module sadc_core_model #(
  parameter logic [6:0] CAL_FACTOR = 7'h2B
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [4:0] channel_select,
  input wire logic core_power,
  output logic [11:0] core_result,
  output logic [6:0] core_cal_factor
);
  // =====
  // Core.
  // Unpowered, the lines flip every cycle so a stale value is never taken for a result.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      core_result <= 12'h000;
      core_cal_factor <= 7'h00;
    end else if (core_power) begin
      core_result <= {7'h53, channel_select};
      core_cal_factor <= CAL_FACTOR;
    end else begin
      core_result <= ~core_result;
      core_cal_factor <= ~core_cal_factor;
    end
  end
endmodule : sadc_core_model

// ===== testbench/sadc_properties.sv
// Concurrent checks on the ports of the converter sequencer.
// Assumes it is bound into sadc_top and the constants header is on the include path.
`timescale 1ns/100ps
`include "sadc_params.svh"
module sadc_properties (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic window_event,
  input wire logic [4:0] channel_select,
  input wire logic core_sample,
  input wire logic core_power,
  input wire logic temp_sensor_enable,
  input wire logic irq
);
  logic [7:0] ien_m;
  logic temp_sensor_enable_m;
  logic msk16_m;
  logic cal_wr;
  logic ien_zero;
  // =====
  // Helper logic.
  // The enable bits are mirrored from snooped writes, as they are not visible at the ports.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ien_m <= 8'h00;
    end else if (reg_wr && reg_addr == `SADC_OFF_IEN) begin
      ien_m <= reg_wdata[7:0];
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_sensor_enable_m <= 1'b0;
      msk16_m <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == `SADC_OFF_CCFG) temp_sensor_enable_m <= reg_wdata[`SADC_CCFG_TEMP_SENSOR_ENABLE];
      if (reg_addr == `SADC_OFF_CHSEL) msk16_m <= reg_wdata[16];
    end
  end
  assign cal_wr = reg_wr && reg_addr == `SADC_OFF_CTRL && reg_wdata[31] && !reg_wdata[0];
  assign ien_zero = reg_wr && reg_addr == `SADC_OFF_IEN && reg_wdata[7:0] == 8'h00;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // =====
  // Assertions.
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a read");
  a_cal_power: assert property (cal_wr |-> ##2 core_power)
    else $error("core not powered during calibration");
  a_cal_quiet: assert property (cal_wr |=> (!core_sample) [*8])
    else $error("sampling during calibration");
  a_sample_len: assert property ($rose(core_sample) |=> core_sample ##1 !core_sample)
    else $error("sample phase not two cycles");
  a_chan_hold: assert property (core_sample && $past(core_sample) |-> $stable(channel_select))
    else $error("channel moved while sampling");
  a_chan_range: assert property (core_sample |-> channel_select <= 5'd18)
    else $error("channel beyond 18 sampled");
  a_temp_gate: assert property (temp_sensor_enable == $past(temp_sensor_enable_m && msk16_m))
    else $error("temperature sensor power does not follow its enable");
  a_irq_masked: assert property (ien_zero |-> ##2 !irq)
    else $error("interrupt with all enables clear");
  a_window_irq: assert property (window_event && ien_m[7] |-> ##2 irq)
    else $error("window event did not interrupt");
endmodule : sadc_properties

bind sadc_top sadc_properties i_props (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .window_event(window_event), .channel_select(channel_select), .core_sample(core_sample),
  .core_power(core_power), .temp_sensor_enable(temp_sensor_enable), .irq(irq));

// ===== testbench/sadc_top_tb.sv
// Self-checking bench for the converter sequencer with its core model.
// Assumes the design, checker and core model are compiled before it.
`timescale 1ns/100ps
`include "sadc_params.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
  $display("wrong value at %0t ns: %h not %h", $time, a, b); end end
module sadc_top_tb;
  logic clk, arst_n, reg_wr, reg_rd, ext_trigger_pin, window_event;
  logic core_sample, core_power, temp_sensor_enable, irq;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [4:0] timer_trigger_input, channel_select;
  logic [11:0] core_result;
  logic [6:0] core_cal_factor;
  int error_cnt, tests_run;
  localparam logic [6:0] CAL = 7'h2B;
  sadc_top i_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_trigger_input(timer_trigger_input), .ext_trigger_pin(ext_trigger_pin),
    .core_result(core_result), .core_cal_factor(core_cal_factor),
    .window_event(window_event), .channel_select(channel_select), .core_sample(core_sample),
    .core_power(core_power), .temp_sensor_enable(temp_sensor_enable), .irq(irq));
  sadc_core_model #(.CAL_FACTOR(CAL)) i_core (.clk(clk), .arst_n(arst_n),
    .channel_select(channel_select), .core_power(core_power), .core_result(core_result),
    .core_cal_factor(core_cal_factor));
  // =====
  // Bus and helper tasks.
  function automatic logic [11:0] res(input logic [4:0] ch);
    return {7'h53, ch};
  endfunction : res
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wait_sts(input int b);
    for (int k = 0; k < 60; k++) begin
      rd(`SADC_OFF_STS);
      if (d[b] === 1'b1) return;
    end
    give_up("status poll");
  endtask : wait_sts
  task automatic give_up(input string what);
    error_cnt++;
    $display("wrong value at %0t ns: %s timed out", $time, what);
    tally_and_finish();
  endtask : give_up
  // =====
  // Scenarios.
  task automatic t_reset();
    logic [7:0] offs [6] = '{`SADC_OFF_STS, `SADC_OFF_IEN, `SADC_OFF_CTRL, `SADC_OFF_CFG1,
      `SADC_OFF_DATA, 8'h3C};
    wr(8'h3C, 32'hFFFF_FFFF);
    foreach (offs[i]) begin
      rd(offs[i]);
      `CHK(d, 32'h0)
    end
    `CHK(irq, 1'b0)
    $display("reset test done");
  endtask : t_reset
  task automatic t_cal();
    wr(`SADC_OFF_CTRL, 32'h8000_0000);
    rd(`SADC_OFF_CTRL);
    `CHK(d[31], 1'b1)
    for (int k = 0; k < 30 && d[31] !== 1'b0; k++) rd(`SADC_OFF_CTRL);
    if (d[31] !== 1'b0) give_up("calibration");
    `CHK(d[31], 1'b0)
    rd(`SADC_OFF_DATA);
    `CHK(d[6:0], CAL)
    wr(`SADC_OFF_CTRL, 32'h1);
    wait_sts(`SADC_B_RDY);
    wr(`SADC_OFF_STS, 32'h0);
    rd(`SADC_OFF_STS);
    `CHK(d[`SADC_B_RDY], 1'b1)
    wr(`SADC_OFF_STS, 32'h1);
    rd(`SADC_OFF_STS);
    `CHK(d[`SADC_B_RDY], 1'b0)
    $display("calibration test done");
  endtask : t_cal
  task automatic t_modes();
    logic [4:0] seq [3] = '{5'd0, 5'd1, 5'd5};
    wr(`SADC_OFF_CHSEL, 32'h23);
    wr(`SADC_OFF_CTRL, 32'h5);
    wait_sts(`SADC_B_EOSEQ);
    `CHK(d[`SADC_B_EOC], 1'b1)
    `CHK(d[`SADC_B_OVR], 1'b1)
    rd(`SADC_OFF_DATA);
    `CHK(d, {20'h0, res(5'd5)})
    wr(`SADC_OFF_STS, 32'h9F);
    cyc(80);
    rd(`SADC_OFF_STS);
    `CHK(d[3:2], 2'b00)
    wr(`SADC_OFF_CFG1, 32'h1_0000);
    foreach (seq[i]) begin
      wr(`SADC_OFF_CTRL, 32'h5);
      wait_sts(`SADC_B_EOC);
      `CHK(d[`SADC_B_EOSEQ], 1'(i == 2))
      rd(`SADC_OFF_DATA);
      `CHK(d, {20'h0, res(seq[i])})
      wr(`SADC_OFF_STS, 32'h9F);
    end
    wr(`SADC_OFF_CFG1, 32'h2000);
    wr(`SADC_OFF_CHSEL, 32'h4);
    wr(`SADC_OFF_CTRL, 32'h5);
    repeat (3) begin
      wait_sts(`SADC_B_EOC);
      wr(`SADC_OFF_STS, 32'h9F);
    end
    rd(`SADC_OFF_DATA);
    `CHK(d, {20'h0, res(5'd2)})
    wr(`SADC_OFF_CTRL, 32'h0);
    cyc(40);
    wr(`SADC_OFF_STS, 32'h9F);
    wr(`SADC_OFF_CTRL, 32'h1);
    wait_sts(`SADC_B_RDY);
    $display("mode test done");
  endtask : t_modes
  task automatic t_trig();
    wr(`SADC_OFF_CHSEL, 32'h8);
    for (int c = 0; c < 8; c++) begin
      wr(`SADC_OFF_CFG1, {20'h0, 2'b01, 1'b0, c[2:0], 6'h0});
      if (c == 7) ext_trigger_pin <= 1'b1;
      else if (c > 4) {ext_trigger_pin, timer_trigger_input} <= 6'h3F;
      else timer_trigger_input[c] <= 1'b1;
      cyc(40);
      rd(`SADC_OFF_STS);
      `CHK(d[`SADC_B_EOC], 1'(c < 5 || c == 7))
      wr(`SADC_OFF_STS, 32'h9F);
      ext_trigger_pin <= 1'b0;
      timer_trigger_input <= 5'h00;
      cyc(40);
      rd(`SADC_OFF_STS);
      `CHK(d[`SADC_B_EOC], 1'b0)
    end
    for (int c = 0; c < 4; c++) begin
      wr(`SADC_OFF_CFG1, {20'h0, c[1:0], 4'h7, 6'h0});
      ext_trigger_pin <= 1'b1;
      cyc(3);
      ext_trigger_pin <= 1'b0;
      cyc(60);
      rd(`SADC_OFF_STS);
      `CHK(d[`SADC_B_EOC], 1'(c != 0))
      cyc(40);
      wr(`SADC_OFF_STS, 32'h9F);
    end
    $display("trigger test done");
  endtask : t_trig
  task automatic t_time();
    int n [4];
    int dif [4] = '{0, 1, 3, 5};
    int k;
    wr(`SADC_OFF_CHSEL, 32'h10);
    wr(`SADC_OFF_IEN, 32'h4);
    for (int r = 0; r < 4; r++) begin
      wr(`SADC_OFF_CFG1, {27'h0, r[1:0], 3'h0});
      wr(`SADC_OFF_CTRL, 32'h5);
      for (k = 0; k < 100 && irq !== 1'b1; k++) @(posedge clk);
      if (k == 100) give_up("interrupt wait");
      n[r] = k;
      `CHK(n[r], n[0] - dif[r])
      `CHK(irq, 1'b1)
      wr(`SADC_OFF_STS, 32'h9F);
      cyc(2);
      `CHK(irq, 1'b0)
    end
    wr(`SADC_OFF_CFG1, 32'h20);
    wr(`SADC_OFF_CTRL, 32'h5);
    wait_sts(`SADC_B_EOC);
    rd(`SADC_OFF_DATA);
    `CHK(d, {16'h0, res(5'd4), 4'h0})
    wr(`SADC_OFF_IEN, 32'h0);
    wr(`SADC_OFF_STS, 32'h9F);
    $display("timing test done");
  endtask : t_time
  task automatic t_temp();
    logic seen;
    wr(`SADC_OFF_CFG1, 32'h0);
    wr(`SADC_OFF_CHSEL, 32'h7_0000);
    for (int t = 0; t < 2; t++) begin
      wr(`SADC_OFF_CCFG, {8'h0, t[0], 23'h0});
      wr(`SADC_OFF_CTRL, 32'h5);
      seen = 1'b0;
      repeat (80) begin
        @(posedge clk);
        if (temp_sensor_enable === 1'b1) seen = 1'b1;
      end
      `CHK(seen, t[0])
      rd(`SADC_OFF_DATA);
      `CHK(d, {20'h0, res(5'd18)})
      wr(`SADC_OFF_STS, 32'h9F);
    end
    wr(`SADC_OFF_IEN, 32'h80);
    window_event <= 1'b1;
    @(posedge clk);
    window_event <= 1'b0;
    cyc(2);
    `CHK(irq, 1'b1)
    rd(`SADC_OFF_STS);
    `CHK(d[`SADC_B_AWD], 1'b1)
    wr(`SADC_OFF_STS, 32'h80);
    cyc(2);
    `CHK(irq, 1'b0)
    $display("sensor and window test done");
  endtask : t_temp
  // =====
  // Clock, reset and sequence.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    {arst_n, reg_wr, reg_rd, ext_trigger_pin, window_event} = 5'h00;
    {reg_addr, reg_wdata, d, timer_trigger_input} = 77'h0;
    error_cnt = 0;
    tests_run = 0;
    cyc(8);
    arst_n <= 1'b1;
    t_reset();
    t_cal();
    t_modes();
    t_trig();
    t_time();
    t_temp();
    tally_and_finish();
  end
endmodule : sadc_top_tb
